// file: rtl/rspc_pkg.sv
package rspc_pkg;

   // ------------------------------------------------------------
   // Clock and reset timer
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int RESET_TIMER_PERIOD_US = 18000;
   localparam int RESET_TIMER_CYCLES = RESET_TIMER_PERIOD_US * CLK_MHZ;
   localparam int TIMER_W = 21;
   localparam logic [TIMER_W-1:0] TIMER_RESET = 21'h000000;

   // ------------------------------------------------------------
   // Program counter
   // ------------------------------------------------------------
   localparam int PC_W = 11;
   localparam int INSTR_W = 12;
   localparam int PAGE_LSB = 9;
   localparam logic [PC_W-1:0] PC_MASK_512 = 11'h1ff;
   localparam logic [PC_W-1:0] PC_MASK_1K = 11'h3ff;
   localparam logic [PC_W-1:0] PC_MASK_2K = 11'h7ff;
   localparam logic [PC_W-1:0] PC_ZERO = 11'h000;
   localparam logic [INSTR_W-1:0] NO_OPERATION_INSTRUCTION = 12'h000;

   // Program memory size straps
   localparam logic [1:0] MEM_512 = 2'h0;
   localparam logic [1:0] MEM_1K = 2'h1;
   localparam logic [1:0] MEM_2K = 2'h2;

   // ------------------------------------------------------------
   // Instruction clock and data banking
   // ------------------------------------------------------------
   localparam logic [1:0] PHASE_RESET = 2'h0;
   localparam logic [1:0] PHASE_LAST = 2'h3;
   localparam logic [1:0] PHASE_PRE_LAST = 2'h2;
   localparam int BANK_LSB = 5;
   localparam logic [1:0] BANK_RESET = 2'h0;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      RSPC_ST_WAIT_MASTER_CLEAR_INPUT = 2'b00,
      RSPC_ST_COUNT = 2'b01,
      RSPC_ST_RUN = 2'b11
   } rspc_state_t;

   typedef struct packed {
      logic strobe;
      logic [PC_W-1:0] addr;
   } rspc_fetch_t;

   typedef struct packed {
      logic big_data;
      logic rc_mode;
      logic [1:0] mem_sel;
   } rspc_strap_t;

endpackage

// file: rtl/rspc_top.sv
`timescale 1ns/10ps
`default_nettype none

module rspc_top
   import rspc_pkg::*;
#(
   parameter int P_TIMER_CYCLES = RESET_TIMER_CYCLES
)
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_master_clear_input,
   input wire rspc_strap_t i_strap,
   input wire logic [INSTR_W-1:0] i_fetch_word,
   input wire logic i_pc_load,
   input wire logic [PAGE_LSB-1:0] i_load_addr,
   input wire logic [1:0] i_status_page,
   input wire logic [7:0] i_file_select_pointer,
   output logic o_chip_reset,
   output logic o_instruction_clock_output,
   output rspc_fetch_t o_fetch,
   output logic [1:0] o_bank
);

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // Width per size
   function automatic logic [PC_W-1:0] f_mask(input logic [1:0] sel);
      return (sel == MEM_512) ? PC_MASK_512
         : (sel == MEM_1K) ? PC_MASK_1K : PC_MASK_2K;
   endfunction
   function automatic logic [PC_W-1:0] f_wrap(input logic [PC_W-1:0] a,
                                              input logic [1:0] sel);
      return a & f_mask(sel);
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic master_clear_input_meta_q;
   logic master_clear_input_s_q;
   rspc_strap_t strap_meta_q;
   rspc_strap_t strap_s_q;

   always_ff @(posedge i_mclk)
   begin
      master_clear_input_meta_q <= i_master_clear_input;
      master_clear_input_s_q <= master_clear_input_meta_q;
      strap_meta_q <= i_strap;
      strap_s_q <= strap_meta_q;
   end

   // ------------------------------------------------------------
   // Reset latch and reset timer
   // ------------------------------------------------------------
   rspc_state_t state_q;
   rspc_state_t state_d;
   logic [TIMER_W-1:0] timer_q;
   logic [TIMER_W-1:0] timer_d;
   logic timer_done;

   assign timer_done = (timer_q == TIMER_W'(P_TIMER_CYCLES - 1));

   always_comb
   begin
      state_d = state_q;
      timer_d = timer_q;
      unique case (state_q)
         RSPC_ST_WAIT_MASTER_CLEAR_INPUT:
         begin
            timer_d = TIMER_RESET;
            if (master_clear_input_s_q)
            begin
               state_d = RSPC_ST_COUNT;
            end
         end
         RSPC_ST_COUNT:
         begin
            timer_d = timer_q + TIMER_W'(1);
            if (!master_clear_input_s_q)
            begin
               state_d = RSPC_ST_WAIT_MASTER_CLEAR_INPUT;
               timer_d = TIMER_RESET;
            end
            else if (timer_done)
            begin
               state_d = RSPC_ST_RUN;
               timer_d = TIMER_RESET;
            end
         end
         RSPC_ST_RUN:
         begin
            if (!master_clear_input_s_q)
            begin
               state_d = RSPC_ST_WAIT_MASTER_CLEAR_INPUT;
            end
         end
         default:
         begin
            state_d = RSPC_ST_WAIT_MASTER_CLEAR_INPUT;
            timer_d = TIMER_RESET;
         end
      endcase
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         state_q <= RSPC_ST_WAIT_MASTER_CLEAR_INPUT;
         timer_q <= TIMER_RESET;
      end
      else
      begin
         state_q <= state_d;
         timer_q <= timer_d;
      end
   end

   assign o_chip_reset = (state_q != RSPC_ST_RUN);

   // ------------------------------------------------------------
   // Instruction clock
   // ------------------------------------------------------------
   logic [1:0] phase_q;
   logic [1:0] phase_d;
   logic instruction_clock_output_q;
   logic instruction_clock_output_d;

   always_comb
   begin
      phase_d = phase_q + 2'h1;
      instruction_clock_output_d = strap_s_q.rc_mode & phase_d[1];
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         phase_q <= PHASE_RESET;
         instruction_clock_output_q <= 1'b0;
      end
      else
      begin
         phase_q <= phase_d;
         instruction_clock_output_q <= instruction_clock_output_d;
      end
   end

   assign o_instruction_clock_output = instruction_clock_output_q;

   // ------------------------------------------------------------
   // Program counter
   // ------------------------------------------------------------
   logic [1:0] size_q;
   logic [1:0] size_d;
   logic [PC_W-1:0] pc_q;
   logic [PC_W-1:0] pc_d;
   logic fetch_q;
   logic fetch_d;
   logic [1:0] bank_q;
   logic [1:0] bank_d;

   always_comb
   begin
      size_d = size_q;
      pc_d = pc_q;
      fetch_d = (state_q == RSPC_ST_RUN) && (phase_q == PHASE_PRE_LAST);
      bank_d = BANK_RESET;
      if (state_q != RSPC_ST_RUN)
      begin
         size_d = strap_s_q.mem_sel;
         pc_d = f_mask(size_d);
      end
      else if (fetch_q)
      begin
         if (i_pc_load)
         begin
            pc_d = f_wrap({i_status_page, i_load_addr}, size_q);
         end
         else
         begin
            pc_d = f_wrap(pc_q + PC_W'(1), size_q);
         end
      end
      if (strap_s_q.big_data)
      begin
         bank_d = i_file_select_pointer[BANK_LSB+1:BANK_LSB];
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_sys_rst)
      begin
         size_q <= MEM_2K;
         pc_q <= PC_MASK_2K;
         fetch_q <= 1'b0;
         bank_q <= BANK_RESET;
      end
      else
      begin
         size_q <= size_d;
         pc_q <= pc_d;
         fetch_q <= fetch_d;
         bank_q <= bank_d;
      end
   end

   assign o_fetch = {fetch_q, pc_q};
   assign o_bank = bank_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_por_sets_latch;
      @(posedge i_mclk)
      i_sys_rst |=> o_chip_reset && (timer_q == TIMER_RESET);
   endproperty
   a_por_sets_latch: assert property (p_por_sets_latch)
      else $error("Power-up did not set latch and clear timer");
   property p_timer_idle;
      @(posedge i_mclk) disable iff (i_sys_rst)
      (state_q == RSPC_ST_WAIT_MASTER_CLEAR_INPUT) && !master_clear_input_s_q
      |=> (timer_q == TIMER_RESET) && o_chip_reset;
   endproperty
   a_timer_idle: assert property (p_timer_idle)
      else $error("Reset timer moved while master clear low");
   property p_timeout_release;
      @(posedge i_mclk) disable iff (i_sys_rst)
      (state_q == RSPC_ST_COUNT) && timer_done && master_clear_input_s_q
      |=> !o_chip_reset ##0 $fell(o_chip_reset);
   endproperty
   a_timeout_release: assert property (p_timeout_release)
      else $error("Latch not released at time-out");
   property p_early_hold;
      @(posedge i_mclk) disable iff (i_sys_rst)
      (state_q == RSPC_ST_COUNT) && !timer_done |=> o_chip_reset;
   endproperty
   a_early_hold: assert property (p_early_hold)
      else $error("Latch released before time-out");
   property p_run_stays;
      @(posedge i_mclk) disable iff (i_sys_rst)
      !o_chip_reset && master_clear_input_s_q |=> !o_chip_reset;
   endproperty
   a_run_stays: assert property (p_run_stays)
      else $error("Internal reset without power-up or master clear");
   property p_instruction_clock_output_div4;
      @(posedge i_mclk) disable iff (i_sys_rst)
      strap_s_q.rc_mode[*2] ##1 $rose(o_instruction_clock_output)
      && strap_s_q.rc_mode ##1 strap_s_q.rc_mode[*3]
      |-> $past(o_instruction_clock_output, 2)
      && !$past(o_instruction_clock_output) && !o_instruction_clock_output;
   endproperty
   a_instruction_clock_output_div4: assert property (p_instruction_clock_output_div4)
      else $error("Instruction clock not oscillator over four");
   property p_pc_in_range;
      @(posedge i_mclk) disable iff (i_sys_rst)
      (pc_q & ~f_mask(size_q)) == PC_ZERO;
   endproperty
   a_pc_in_range: assert property (p_pc_in_range)
      else $error("Program counter beyond memory width");
   property p_wrap_top;
      @(posedge i_mclk) disable iff (i_sys_rst)
      fetch_q && !o_chip_reset && !i_pc_load && pc_q == f_mask(size_q)
      |=> pc_q == PC_ZERO;
   endproperty
   a_wrap_top: assert property (p_wrap_top)
      else $error("Top address did not wrap to zero");
   property p_vector_in_reset;
      @(posedge i_mclk) disable iff (i_sys_rst)
      o_chip_reset ##1 o_chip_reset |-> pc_q == f_mask(size_q);
   endproperty
   a_vector_in_reset: assert property (p_vector_in_reset)
      else $error("Program counter not at reset vector");
   property p_nop_restart;
      @(posedge i_mclk) disable iff (i_sys_rst)
      fetch_q && !o_chip_reset && !i_pc_load
      && i_fetch_word == NO_OPERATION_INSTRUCTION && pc_q == f_mask(size_q)
      |=> pc_q == PC_ZERO ##3 o_fetch.strobe && o_fetch.addr == PC_ZERO;
   endproperty
   a_nop_restart: assert property (p_nop_restart)
      else $error("No-operation at vector did not restart at zero");
   property p_page_load;
      @(posedge i_mclk) disable iff (i_sys_rst)
      fetch_q && !o_chip_reset && i_pc_load
      |=> pc_q == f_wrap({$past(i_status_page), $past(i_load_addr)}, size_q);
   endproperty
   a_page_load: assert property (p_page_load)
      else $error("Paged load gave wrong address");
   property p_bank;
      @(posedge i_mclk) disable iff (i_sys_rst)
      strap_s_q.big_data
      |=> o_bank == $past(i_file_select_pointer[BANK_LSB+1:BANK_LSB]);
   endproperty
   a_bank: assert property (p_bank)
      else $error("Bank not taken from pointer bits");
   property p_no_fetch_in_reset;
      @(posedge i_mclk) disable iff (i_sys_rst)
      o_chip_reset |=> !o_fetch.strobe;
   endproperty
   a_no_fetch_in_reset: assert property (p_no_fetch_in_reset)
      else $error("Fetch while reset latch set");

   c_release: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
      $fell(o_chip_reset));
   c_nop_wrap: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
      fetch_q && pc_q == f_mask(size_q) ##1 pc_q == PC_ZERO);
   c_page_load: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
      fetch_q && i_pc_load && i_status_page != 2'h0);
   c_instruction_clock_output: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
      $rose(o_instruction_clock_output));

endmodule

`default_nettype wire

// file: tb/rspc_master_clear_input_model.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------
// Reset circuit driving the master clear pin
// ------------------------------------------------
module rspc_master_clear_input_model
(
   input wire logic i_mclk,
   input wire logic i_hold,
   input wire logic [7:0] i_delay,
   output logic o_master_clear_input
);
   logic [7:0] cnt_q = 8'h00;

   // Slow ramp: pin rises i_delay cycles after release
   always_ff @(posedge i_mclk)
   begin
      if (i_hold)
         cnt_q <= 8'h00;
      else if (cnt_q != i_delay)
         cnt_q <= cnt_q + 8'h01;
   end

   assign o_master_clear_input = !i_hold && (cnt_q == i_delay);
endmodule

`default_nettype wire

// file: tb/rspc_top_test.sv
`timescale 1ns/10ps
`default_nettype none

module rspc_top_test;
   import rspc_pkg::*;
   localparam int P = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hold = 1'b1;
   logic load = 1'b0;
   logic [7:0] dly = 8'h00;
   logic [7:0] file_select_pointer = 8'h00;
   logic [8:0] laddr = 9'h000;
   logic [1:0] page = 2'h0;
   logic [11:0] word = 12'h000;
   rspc_strap_t strap = '0;
   logic master_clear_input;
   logic chip_rst;
   logic clk_out;
   rspc_fetch_t fetch;
   logic [1:0] bank;
   int mismatches = 0;
   int n_checks = 0;

   always #5 clk = ~clk;

   rspc_master_clear_input_model u_master_clear_input (.i_mclk(clk), .i_hold(hold), .i_delay(dly),
      .o_master_clear_input(master_clear_input));

   rspc_top #(.P_TIMER_CYCLES(P)) DUT (.i_mclk(clk), .i_sys_rst(rst),
      .i_master_clear_input(master_clear_input), .i_strap(strap), .i_fetch_word(word),
      .i_pc_load(load), .i_load_addr(laddr), .i_status_page(page),
      .i_file_select_pointer(file_select_pointer), .o_chip_reset(chip_rst),
      .o_instruction_clock_output(clk_out), .o_fetch(fetch), .o_bank(bank));

   // ------------------------------------------------
   // Shared helpers
   // ------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   function automatic logic [10:0] mask_of(input logic [1:0] m);
      return (m == MEM_512) ? PC_MASK_512 : (m == MEM_1K) ? PC_MASK_1K
         : PC_MASK_2K;
   endfunction

   task automatic next_strobe(output int gap);
      gap = 0;
      do
      begin
         tick(1);
         gap++;
      end
      while (fetch.strobe !== 1'b1 && gap < 8);
   endtask

   task automatic release_and_time(input int d);
      int n;
      hold = 1'b0;
      n = 0;
      while (chip_rst === 1'b1 && n < 200)
      begin
         tick(1);
         n++;
      end
      check(32'(n >= P + d + 2 && n <= P + d + 4), 32'h1);
   endtask

   task automatic boot(input logic [1:0] mem, input int d);
      strap.mem_sel = mem;
      dly = 8'(d);
      hold = 1'b1;
      rst = 1'b1;
      tick(16);
      check(32'(chip_rst), 32'h1);
      rst = 1'b0;
      tick(30);
      check(32'(fetch.addr), 32'(mask_of(mem)));
      check(32'(chip_rst), 32'h1);
      check(32'(fetch.strobe), 32'h0);
      release_and_time(d);
   endtask

   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task automatic t_fetch(input logic [1:0] mem);
      int g;
      logic [10:0] m;
      m = mask_of(mem);
      boot(mem, 3 * int'(mem));
      next_strobe(g);
      check(32'(fetch.addr), 32'(m));
      word = NO_OPERATION_INSTRUCTION;
      next_strobe(g);
      check(32'(g), 32'h4);
      check(32'(fetch.addr), 32'(PC_ZERO));
      load = 1'b1;
      page = 2'h1;
      laddr = 9'h0a5;
      next_strobe(g);
      check(32'(fetch.addr), 32'(11'h2a5 & m));
      load = 1'b1;
      page = 2'h3;
      laddr = 9'h1ff;
      next_strobe(g);
      check(32'(fetch.addr), 32'(m));
      load = 1'b0;
      word = 12'h0a5;
      next_strobe(g);
      check(32'(fetch.addr), 32'(PC_ZERO));
      $display("Test done: fetch size %0d", mem);
   endtask

   task automatic t_abort();
      hold = 1'b1;
      dly = 8'h00;
      tick(6);
      check(32'(chip_rst), 32'h1);
      // Cut the count short, then expect a full restart
      hold = 1'b0;
      tick(P / 2);
      check(32'(chip_rst), 32'h1);
      hold = 1'b1;
      tick(6);
      check(32'(chip_rst), 32'h1);
      release_and_time(0);
      $display("Test done: master clear abort");
   endtask

   task automatic t_clock();
      int hi;
      int tg;
      logic prev;
      strap.rc_mode = 1'b1;
      tick(6);
      hi = 0;
      tg = 0;
      prev = clk_out;
      repeat (16)
      begin
         tick(1);
         hi += int'(clk_out === 1'b1);
         tg += int'(clk_out !== prev);
         prev = clk_out;
      end
      check(32'(hi), 32'h8);
      check(32'(tg), 32'h8);
      strap.rc_mode = 1'b0;
      tick(6);
      check(32'(clk_out), 32'h0);
      $display("Test done: clock out");
   endtask

   task automatic t_bank();
      strap.big_data = 1'b1;
      for (int b = 0; b < 4; b++)
      begin
         file_select_pointer = {1'b1, 2'(b), 5'h15};
         tick(5);
         check(32'(bank), 32'(b));
      end
      strap.big_data = 1'b0;
      tick(5);
      check(32'(bank), 32'(BANK_RESET));
      $display("Test done: bank select");
   endtask

   // ------------------------------------------------
   // Run control
   // ------------------------------------------------
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end

   initial
   begin
      for (int m = 0; m < 4; m++)
         t_fetch(2'(m));
      t_abort();
      t_clock();
      t_bank();
      report_and_stop();
   end
endmodule

`default_nettype wire
